// [design/fsp_ctrl.sv]
// Host controller for flash secured region and sector group protection
// Overview of operation
// - Host protects region with three-cycle enter, then protect at normal reset.
// - Host issues exit before touching the rest of the main array.
// - Group protect and unprotect need elevated reset plus ordinary bus cycles.
// - Host protects every unprotected group before the first unprotect write.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module fsp_ctrl (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Register bus
  input  wire fsp_pkg::fsp_axi_req_s axi_req,
  output fsp_pkg::fsp_axi_rsp_s     axi_rsp,
  // Flash pins
  input  wire logic [15:0]          dq_in,
  output fsp_pkg::fsp_pins_s        pins
);
  import fsp_pkg::*;
  typedef struct packed {
    fsp_axi_rsp_s rsp;
    fsp_pins_s    pins;
    fsp_state_e   state;
    logic [3:0]   op;
    logic [2:0]   step;
    logic [7:0]   cnt;
    logic         elev;
    logic         wp;
    logic         frst;
    logic [22:0]  addr;
    logic [15:0]  wdata;
    logic [15:0]  rdata;
    logic         busy;
    logic         refused;
    logic         mapped;
    logic         rlock;
    logic         qres;
    logic [6:0]   nprot;
    logic [15:0]  dq_s1;
    logic [15:0]  dq_s2;
    logic         mem_wen;
    logic         mem_clr;
  } fsp_main_s;

  fsp_main_s  s;
  fsp_main_s  n;
  fsp_cyc_s   cyc;
  fsp_cyc_s   ncyc;
  logic [3:0] start_op;
  logic       mem_rdata;
  logic [6:0] cur_group;

  // Sector group index from address bits 22 to 15
  function automatic logic [6:0] group_of(input logic [7:0] sa);
    if (sa[7:2] == 6'h00) begin
      group_of = {5'h00, sa[1:0]};
    end else if (sa[7:2] == 6'h3F) begin
      group_of = 7'(TOP_GROUP0 + {5'h00, sa[1:0]});
    end else begin
      group_of = 7'(7'h03 + {1'b0, sa[7:2]});
    end
  endfunction

  // Bus cycle of a given step of an operation
  function automatic fsp_cyc_s seq_cycle(input logic [3:0] op, input logic [2:0] step,
                                         input logic [22:0] a, input logic [15:0] d);
    seq_cycle = '{last: 1'b1, addr: a, data: d};
    if (op == OP_ENTER || op == OP_EXIT) begin
      case (step)
        3'h0: seq_cycle = '{last: 1'b0, addr: CMD_ADDR_A, data: CMD_UNLK_1};
        3'h1: seq_cycle = '{last: 1'b0, addr: CMD_ADDR_B, data: CMD_UNLK_2};
        3'h2: seq_cycle = '{last: op == OP_ENTER, addr: CMD_ADDR_A,
                            data: (op == OP_ENTER) ? CMD_ENTER : CMD_EXIT};
        default: seq_cycle = '{last: 1'b1, addr: CMD_ADDR_Z, data: CMD_EXIT_Z};
      endcase
    end
  endfunction

  // Gate on starting an operation
  function automatic logic op_allowed(input logic [3:0] op, input fsp_main_s st);
    case (op)
      OP_READ, OP_WRITE: op_allowed = !st.mapped || group_of(st.addr[22:15]) == 7'h00;
      OP_ENTER, OP_EXIT, OP_QUERY: op_allowed = 1'b1;
      OP_PROT: op_allowed = st.elev || st.mapped;
      OP_UNPROT: op_allowed = st.elev && !st.mapped && st.nprot == NUM_GROUPS;
      default: op_allowed = 1'b0;
    endcase
  endfunction

  assign cur_group = group_of(s.addr[22:15]);
  fsp_group_mem u_mem (
    .mclk  (mclk),
    .rst   (rst),
    .clr   (s.mem_clr),
    .wen   (s.mem_wen),
    .waddr (cur_group),
    .wbit  (1'b1),
    .raddr (cur_group),
    .rdata (mem_rdata)
  );

  // Register slave, operation sequencer and pin drive
  always_comb begin
    n = s;
    n.mem_wen = 1'b0;
    n.mem_clr = 1'b0;
    n.dq_s1 = dq_in;
    n.dq_s2 = s.dq_s1;
    start_op = OP_NONE;
    cyc = seq_cycle(s.op, s.step, s.addr, s.wdata);
    // Write channel: address and data taken together
    n.rsp.awready = axi_req.awvalid && axi_req.wvalid && !s.rsp.bvalid && !s.rsp.awready;
    n.rsp.wready = n.rsp.awready;
    if (s.rsp.bvalid && axi_req.bready) n.rsp.bvalid = 1'b0;
    if (s.rsp.awready) begin
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = RESP_OKAY;
      case (axi_req.awaddr[4:0])
        OFS_CTRL: begin
          if (!s.busy) begin
            n.elev = axi_req.wdata[CTRL_ELEV_BIT];
            n.wp = axi_req.wdata[CTRL_WP_BIT];
            n.frst = axi_req.wdata[CTRL_RST_BIT];
            n.mapped = s.mapped && !axi_req.wdata[CTRL_RST_BIT];
          end
          start_op = axi_req.wdata[CTRL_OP_LSB +: 4];
        end
        OFS_ADDR: n.addr = s.busy ? s.addr : axi_req.wdata[22:0];
        OFS_WDATA: n.wdata = s.busy ? s.wdata : axi_req.wdata[15:0];
        OFS_RDATA, OFS_STATUS: n.rsp.bresp = RESP_OKAY;
        default: n.rsp.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    n.rsp.arready = axi_req.arvalid && !s.rsp.rvalid && !s.rsp.arready;
    if (s.rsp.rvalid && axi_req.rready) n.rsp.rvalid = 1'b0;
    if (s.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = RESP_OKAY;
      n.rsp.rdata = 32'h00000000;
      case (axi_req.araddr[4:0])
        OFS_CTRL: n.rsp.rdata[CTRL_RST_BIT:CTRL_ELEV_BIT] = {s.frst, s.wp, s.elev};
        OFS_ADDR: n.rsp.rdata[22:0] = s.addr;
        OFS_WDATA: n.rsp.rdata[15:0] = s.wdata;
        OFS_RDATA: n.rsp.rdata[15:0] = s.rdata;
        OFS_STATUS: begin
          n.rsp.rdata[STAT_BUSY_BIT] = s.busy;
          n.rsp.rdata[STAT_REFUSED_BIT] = s.refused;
          n.rsp.rdata[STAT_MAPPED_BIT] = s.mapped;
          n.rsp.rdata[STAT_ALLPROT_BIT] = s.nprot == NUM_GROUPS;
          n.rsp.rdata[STAT_QUERY_BIT] = s.qres;
          n.rsp.rdata[STAT_RLOCK_BIT] = s.rlock;
        end
        default: n.rsp.rresp = RESP_SLVERR;
      endcase
    end
    // Operation start or refusal
    if (start_op != OP_NONE) begin
      n.refused = s.busy || s.frst || !op_allowed(start_op, s);
      if (!n.refused) begin
        n.busy = 1'b1;
        n.op = start_op;
        n.step = 3'h0;
        n.cnt = CYC_SETUP;
        n.state = (start_op == OP_QUERY) ? ST_LOOK : ST_SETUP;
      end
    end
    // Sequencer
    case (s.state)
      ST_IDLE: begin
      end
      ST_SETUP: begin
        n.cnt = 8'(s.cnt - 8'h01);
        if (s.cnt == 8'h01) begin
          n.state = ST_STROBE;
          n.cnt = CYC_STROBE;
        end
      end
      ST_STROBE: begin
        n.cnt = 8'(s.cnt - 8'h01);
        if (s.cnt == 8'h01) begin
          if (s.op == OP_READ) n.rdata = s.dq_s2;
          n.state = ST_HOLD;
          n.cnt = CYC_HOLD;
        end
      end
      ST_HOLD: begin
        n.cnt = 8'(s.cnt - 8'h01);
        if (s.cnt == 8'h01) begin
          n.state = ST_IDLE;
          n.busy = 1'b0;
          if (!cyc.last) begin
            n.step = 3'(s.step + 3'h1);
            n.state = ST_SETUP;
            n.cnt = CYC_SETUP;
            n.busy = 1'b1;
          end else if (s.op == OP_ENTER || s.op == OP_EXIT) begin
            n.mapped = s.op == OP_ENTER;
          end else if (s.op == OP_UNPROT) begin
            n.mem_clr = 1'b1;
            n.nprot = 7'h00;
          end else if (s.op == OP_PROT && s.mapped) begin
            n.rlock = 1'b1;
          end else if (s.op == OP_PROT) begin
            n.state = ST_LOOK;
            n.busy = 1'b1;
          end
        end
      end
      ST_LOOK: n.state = ST_MARK;
      ST_MARK: begin
        if (s.op == OP_PROT && !mem_rdata) begin
          n.mem_wen = 1'b1;
          n.nprot = 7'(s.nprot + 7'h01);
        end
        if (s.op == OP_QUERY) n.qres = mem_rdata;
        n.state = ST_IDLE;
        n.busy = 1'b0;
      end
      default: begin
        n.state = ST_IDLE;
        n.busy = 1'b0;
      end
    endcase
    // Pins follow the next state
    ncyc = seq_cycle(n.op, n.step, n.addr, n.wdata);
    n.pins.elevated = n.elev;
    n.pins.protect_n = !n.wp;
    n.pins.reset_n = !n.frst;
    n.pins.ce_n = !(n.state inside {ST_SETUP, ST_STROBE, ST_HOLD});
    n.pins.addr = n.pins.ce_n ? s.pins.addr : ncyc.addr;
    n.pins.dq_out = ncyc.data;
    n.pins.dq_oe = !n.pins.ce_n && n.op != OP_READ;
    n.pins.oe_n = !(n.state == ST_STROBE && n.op == OP_READ);
    n.pins.we_n = !(n.state == ST_STROBE && n.op != OP_READ);
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.state <= ST_IDLE;
      s.pins.ce_n <= 1'b1;
      s.pins.oe_n <= 1'b1;
      s.pins.we_n <= 1'b1;
      s.pins.reset_n <= 1'b1;
      s.pins.protect_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign axi_rsp = s.rsp;
  assign pins = s.pins;

  unprot_gate_a : assert property (
    @(posedge mclk) disable iff (rst)
    (!s.pins.we_n && s.op == OP_UNPROT) |-> (s.nprot == NUM_GROUPS && s.pins.elevated))
    else $error("unprotect write issued before all groups were protected");
  prot_level_a : assert property (
    @(posedge mclk) disable iff (rst)
    ($fell(s.pins.we_n) && s.op == OP_PROT) |-> (s.pins.elevated || s.mapped))
    else $error("protect write issued without elevated reset or mapped region");
  exit_first_a : assert property (
    @(posedge mclk) disable iff (rst)
    (!s.pins.ce_n && s.mapped && (s.op == OP_READ || s.op == OP_WRITE))
      |-> group_of(s.pins.addr[22:15]) == 7'h00)
    else $error("main array accessed while secured region is mapped");
  enter_seq_a : assert property (
    @(posedge mclk) disable iff (rst)
    $rose(s.mapped) |-> ($past(s.op) == OP_ENTER && $past(s.step) == 3'h2))
    else $error("region mapped without a complete three-cycle enter");
  elev_steady_a : assert property (
    @(posedge mclk) disable iff (rst)
    (s.busy && s.op == OP_UNPROT) |=> s.pins.elevated [*2])
    else $error("elevated reset dropped during unprotect");
endmodule // fsp_ctrl

// [design/fsp_group_mem.sv]
// Protection bitmap of sector groups with registered read
`timescale 1ns/1ps
module fsp_group_mem (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // Write side
  input  wire logic                         clr,
  input  wire logic                         wen,
  input  wire logic [fsp_pkg::GROUP_W-1:0]  waddr,
  input  wire logic                         wbit,
  // Read side
  input  wire logic [fsp_pkg::GROUP_W-1:0]  raddr,
  output logic                              rdata
);
  import fsp_pkg::*;

  typedef struct packed {
    logic [GROUP_DEPTH-1:0] bits;
    logic                   rdata;
  } fsp_mem_s;

  fsp_mem_s s;
  fsp_mem_s n;

  // Clear wins over a single write
  always_comb begin
    n = s;
    n.rdata = s.bits[raddr];
    if (clr) begin
      n.bits = '0;
    end else if (wen) begin
      n.bits[waddr] = wbit;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
endmodule // fsp_group_mem

// [design/fsp_pkg.sv]
// Shared constants, types and carriers of the flash protection controller
package fsp_pkg;
  // Clock and bus-cycle timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned T_SETUP_NS    = 20;
  localparam int unsigned T_STROBE_NS   = 120;
  localparam int unsigned T_HOLD_NS     = 20;
  localparam logic [7:0]  CYC_SETUP  = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  CYC_STROBE = 8'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  CYC_HOLD   = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Flash geometry
  localparam int unsigned FLASH_AW    = 23;
  localparam int unsigned FLASH_DW    = 16;
  localparam int unsigned GROUP_W     = 7;
  localparam int unsigned GROUP_DEPTH = 128;
  localparam logic [6:0]  NUM_GROUPS  = 7'h46;
  localparam logic [6:0]  TOP_GROUP0  = 7'h42;
  localparam int unsigned INDICATOR_BIT = 7;

  // Register offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_ADDR   = 5'h04;
  localparam logic [4:0] OFS_WDATA  = 5'h08;
  localparam logic [4:0] OFS_RDATA  = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // Control fields
  localparam int unsigned CTRL_OP_LSB   = 0;
  localparam int unsigned CTRL_ELEV_BIT = 8;
  localparam int unsigned CTRL_WP_BIT   = 9;
  localparam int unsigned CTRL_RST_BIT  = 10;

  // Status fields
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_REFUSED_BIT = 1;
  localparam int unsigned STAT_MAPPED_BIT  = 2;
  localparam int unsigned STAT_ALLPROT_BIT = 3;
  localparam int unsigned STAT_QUERY_BIT   = 4;
  localparam int unsigned STAT_RLOCK_BIT   = 5;

  // Operation codes
  localparam logic [3:0] OP_NONE   = 4'h0;
  localparam logic [3:0] OP_READ   = 4'h1;
  localparam logic [3:0] OP_WRITE  = 4'h2;
  localparam logic [3:0] OP_ENTER  = 4'h3;
  localparam logic [3:0] OP_EXIT   = 4'h4;
  localparam logic [3:0] OP_PROT   = 4'h5;
  localparam logic [3:0] OP_UNPROT = 4'h6;
  localparam logic [3:0] OP_QUERY  = 4'h7;

  // Command sequence words
  localparam logic [22:0] CMD_ADDR_A = 23'h000555;
  localparam logic [22:0] CMD_ADDR_B = 23'h0002AA;
  localparam logic [22:0] CMD_ADDR_Z = 23'h000000;
  localparam logic [15:0] CMD_UNLK_1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLK_2 = 16'h0055;
  localparam logic [15:0] CMD_ENTER  = 16'h0088;
  localparam logic [15:0] CMD_EXIT   = 16'h0090;
  localparam logic [15:0] CMD_EXIT_Z = 16'h0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_SETUP  = 6'h02,
    ST_STROBE = 6'h04,
    ST_HOLD   = 6'h08,
    ST_LOOK   = 6'h10,
    ST_MARK   = 6'h20
  } fsp_state_e;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } fsp_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fsp_axi_rsp_s;

  typedef struct packed {
    logic [22:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        reset_n;
    logic        elevated;
    logic        protect_n;
  } fsp_pins_s;

  typedef struct packed {
    logic        last;
    logic [22:0] addr;
    logic [15:0] data;
  } fsp_cyc_s;
endpackage

// [verification/fsp_flash_model.sv]
// Behavioural flash device answering the controller's bus cycles
`timescale 1ns/1ps
module fsp_flash_model #(
  parameter logic INDICATOR = 1'b0
) (
  // Controller pins
  input  fsp_pkg::fsp_pins_s pins,
  output logic [15:0]        dq_in
);
  import fsp_pkg::*;
  logic [15:0] mem [bit [22:0]];
  logic [15:0] region [128];
  logic [69:0] gprot  = '0;
  logic        rlock  = INDICATOR;
  logic        mapped = 1'b0;
  logic [1:0]  step   = 2'd0;
  logic [15:0] dout   = 16'h0000;
  logic        on;

  // Group number from the upper address bits
  function automatic int grp(input logic [22:0] a);
    if (a[22:17] == 6'h00) return int'(a[16:15]);
    if (a[22:17] == 6'h3F) return 66 + int'(a[16:15]);
    return int'(a[22:17]) + 3;
  endfunction

  // Word returned by a read, region or main array
  function automatic logic [15:0] look(input logic [22:0] a);
    if (mapped && a[22:15] == 8'h00) begin
      if (a[22:7] != 16'h0 || (INDICATOR && a[6:3] != 4'h0)) return 16'hFFFF;
      return region[a[6:0]];
    end
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  // Erased region with a fixed word zero
  initial begin
    foreach (region[i]) region[i] = 16'hFFFF;
    region[0] = 16'h0000;
  end

  // Commands, protection and programming; no accelerated or bypass path exists
  always @(posedge pins.we_n) begin
    if (!pins.ce_n) begin
      if (pins.addr == CMD_ADDR_A && pins.dq_out == CMD_UNLK_1) begin
        step = 2'd1;
      end else if (step == 2'd1 && pins.dq_out == CMD_UNLK_2) begin
        step = 2'd2;
      end else if (step == 2'd2 && pins.dq_out == CMD_ENTER) begin
        mapped = 1'b1;
        step = 2'd0;
      end else if (step == 2'd2 && pins.dq_out == CMD_EXIT) begin
        step = 2'd3;
      end else if (step == 2'd3) begin
        mapped = 1'b0;
        step = 2'd0;
      end else if ((pins.elevated || mapped) && pins.dq_out == 16'h0060) begin
        if (mapped) rlock = 1'b1;
        else gprot[grp(pins.addr)] = 1'b1;
      end else if (pins.elevated && pins.dq_out == 16'h0040) begin
        if (&gprot) gprot = '0;
      end else if (mapped) begin
        if (!rlock && pins.addr[22:7] == 16'h0) region[pins.addr[6:0]] = pins.dq_out;
      end else if (pins.protect_n !== 1'b0 || grp(pins.addr) != 69) begin
        if (!gprot[grp(pins.addr)] || pins.elevated) mem[pins.addr] = pins.dq_out;
      end
    end
  end

  // Hardware reset returns the first sector to the main array
  always @(negedge pins.reset_n) begin
    mapped = 1'b0;
    step = 2'd0;
  end

  // Read data while selected, the inverse of the last word once released
  assign on = !pins.ce_n && !pins.oe_n;
  always @(on or pins.addr) begin
    if (on) dout = look(pins.addr);
  end
  assign dq_in = on ? dout : ~dout;
endmodule  // fsp_flash_model

// [verification/test_flash_secure_region_and_sector_protect.sv]
// Self-checking bench of the flash protection controller
`timescale 1ns/1ps
module test_flash_secure_region_and_sector_protect;
  import fsp_pkg::*;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
  } fsp_note_s;
  logic         mclk = 1'b0;
  logic         rst  = 1'b1;
  fsp_axi_req_s req  = '0;
  fsp_axi_rsp_s rsp;
  fsp_pins_s    pins;
  logic [15:0]  dq_in;
  fsp_note_s    rq[$];
  fsp_note_s    bq[$];
  fsp_note_s    nt;
  logic [31:0]  rd_word;
  logic [22:0]  a0;
  logic [15:0]  v0;
  int           n_errors  = 0;
  int           tests_run = 0;

  // Clock
  always #2.5 mclk = ~mclk;

  fsp_ctrl dut (.mclk(mclk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .dq_in(dq_in),
                .pins(pins));
  fsp_flash_model flash (.pins(pins), .dq_in(dq_in));

  // Masked comparison of one result
  task automatic cmp(input string what, input logic [31:0] e, g, m);
    tests_run++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e & m, g & m);
    end
  endtask

  // Compare each answer with the oldest note
  always @(posedge mclk) begin
    if (rsp.rvalid && req.rready) begin
      nt = rq.pop_front();
      if (nt.m != 32'h0) cmp("rdata", nt.d, rsp.rdata, nt.m);
      cmp("rresp", 32'(nt.r), 32'(rsp.rresp), 32'h3);
    end
    if (rsp.bvalid && req.bready) begin
      nt = bq.pop_front();
      cmp("bresp", 32'(nt.r), 32'(rsp.bresp), 32'h3);
    end
  end

  // Register write with address and data offered together
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back('{32'h0, 32'h0, r});
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= {27'h0, a};
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
  endtask

  // Register read, noting the expected word
  task automatic axi_rd(input logic [4:0] a, input logic [31:0] e, m, input logic [1:0] r);
    rq.push_back('{e, m, r});
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr  <= {27'h0, a};
    req.rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    rd_word = rsp.rdata;
  endtask

  // Set control levels, load address and data, start an operation, wait until idle
  // The start gate sees only levels already standing, so they go in a write of their own
  task automatic run_op(input logic [3:0] op, input logic [22:0] a, input logic [15:0] d,
                        input logic [2:0] c);
    axi_wr(OFS_CTRL, {21'h0, c, 8'h00}, RESP_OKAY);
    axi_wr(OFS_ADDR, {9'h0, a}, RESP_OKAY);
    axi_wr(OFS_WDATA, {16'h0, d}, RESP_OKAY);
    axi_wr(OFS_CTRL, {21'h0, c, 4'h0, op}, RESP_OKAY);
    do axi_rd(OFS_STATUS, 32'h0, 32'h0, RESP_OKAY);
    while (rd_word[STAT_BUSY_BIT]);
  endtask

  // Status check and flash word check
  task automatic chk_st(input logic [31:0] e, m);
    axi_rd(OFS_STATUS, e, m, RESP_OKAY);
  endtask
  task automatic rd_main(input logic [22:0] a, input logic [15:0] e);
    run_op(OP_READ, a, 16'h0000, 3'b000);
    axi_rd(OFS_RDATA, {16'h0, e}, 32'h0000FFFF, RESP_OKAY);
  endtask

  // Base address of a sector group
  function automatic logic [22:0] gaddr(input int g);
    if (g < 4) return {6'h00, 2'(g), 15'h0};
    if (g > 65) return {6'h3F, 2'(g - 66), 15'h0};
    return {6'(g - 3), 2'b00, 15'h0};
  endfunction

  // Verdict
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #400000;
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    stop_test();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hC883));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    axi_rd(OFS_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    chk_st(32'h0, 32'h3F);
    axi_rd(5'h14, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    axi_wr(5'h1C, 32'h1, RESP_SLVERR);
    $display("register test done");
    a0 = {6'h05, 17'($urandom)};
    v0 = {2'b10, 14'($urandom)};
    run_op(OP_WRITE, a0, v0, 3'b000);
    rd_main(a0, v0);
    run_op(OP_PROT, a0 ^ 23'h018000, 16'h0060, 3'b001);
    run_op(OP_QUERY, a0, 16'h0000, 3'b000);
    chk_st(32'h10, 32'h10);
    run_op(OP_QUERY, a0 + 23'h020000, 16'h0000, 3'b000);
    chk_st(32'h0, 32'h10);
    run_op(OP_PROT, 23'h010000, 16'h0060, 3'b001);
    run_op(OP_QUERY, 23'h018000, 16'h0000, 3'b000);
    chk_st(32'h0, 32'h10);
    run_op(OP_WRITE, a0, ~v0, 3'b000);
    rd_main(a0, v0);
    run_op(OP_WRITE, a0, ~v0, 3'b001);
    rd_main(a0, ~v0);
    $display("group test done");
    a0 = {8'hFF, 15'($urandom)};
    run_op(OP_WRITE, a0, v0, 3'b010);
    rd_main(a0, 16'hFFFF);
    run_op(OP_WRITE, a0, v0, 3'b000);
    rd_main(a0, v0);
    $display("write protect test done");
    run_op(OP_ENTER, 23'h0, 16'h0000, 3'b000);
    chk_st(32'h4, 32'h4);
    run_op(OP_WRITE, 23'h000001, v0, 3'b000);
    rd_main(23'h000001, v0);
    rd_main(23'h000000, 16'h0000);
    run_op(OP_READ, 23'h008000, 16'h0000, 3'b000);
    chk_st(32'h2, 32'h2);
    run_op(OP_PROT, 23'h000000, 16'h0060, 3'b000);
    chk_st(32'h20, 32'h20);
    run_op(OP_WRITE, 23'h000001, ~v0, 3'b000);
    rd_main(23'h000001, v0);
    run_op(OP_EXIT, 23'h0, 16'h0000, 3'b000);
    chk_st(32'h0, 32'h4);
    rd_main(23'h000001, 16'hFFFF);
    run_op(OP_ENTER, 23'h0, 16'h0000, 3'b000);
    run_op(OP_NONE, 23'h0, 16'h0000, 3'b100);
    chk_st(32'h0, 32'h4);
    run_op(OP_NONE, 23'h0, 16'h0000, 3'b000);
    rd_main(23'h000001, 16'hFFFF);
    $display("region test done");
    run_op(OP_UNPROT, 23'h0, 16'h0040, 3'b001);
    chk_st(32'h2, 32'h2);
    for (int g = 0; g < 70; g++) run_op(OP_PROT, gaddr(g), 16'h0060, 3'b001);
    chk_st(32'h8, 32'h8);
    run_op(OP_UNPROT, 23'h0, 16'h0040, 3'b001);
    chk_st(32'h0, 32'hA);
    run_op(OP_QUERY, gaddr(8), 16'h0000, 3'b000);
    chk_st(32'h0, 32'h10);
    run_op(OP_WRITE, gaddr(8), v0, 3'b000);
    rd_main(gaddr(8), v0);
    $display("unprotect test done");
    stop_test();
  end
endmodule  // test_flash_secure_region_and_sector_protect
